//--- hdl/sic_pkg.sv
package sic_pkg;

	// ----------------------------------------
	// Register byte addresses.
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LIMIT = 8'h04;
	localparam logic [7:0] ADDR_SVC = 8'h08;
	localparam logic [7:0] ADDR_OPT = 8'h0C;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [7:0] ADDR_CLR = 8'h14;
	localparam logic [7:0] ADDR_EN = 8'h18;
	localparam logic [7:0] ADDR_FLAG = 8'h1C;

	// ----------------------------------------
	// Control register layout and encodings.
	// ----------------------------------------
	localparam int CTRL_FN_LSB = 0;
	localparam int CTRL_OP_LSB = 2;
	localparam int CTRL_MON_LSB = 4;
	localparam int CTRL_ACK_LSB = 8;
	localparam int CTRL_W = 12;
	localparam logic [11:0] CTRL_RST = 12'h000;
	localparam logic [1:0] FN_SWITCH = 2'h0;
	localparam logic [1:0] FN_HOURS = 2'h1;
	localparam logic [1:0] FN_DAYS = 2'h2;
	localparam logic [1:0] OP_OFF = 2'h0;
	localparam logic [1:0] OP_HOURS = 2'h1;
	localparam logic [1:0] OP_DAYS = 2'h2;
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam int NBIN = 8;

	// ----------------------------------------
	// Counter widths, limit and reset values.
	// ----------------------------------------
	localparam int CNT_W = 24;
	localparam logic [23:0] LIMIT_MAX = 24'h989680;
	localparam logic [23:0] LIMIT_RST = 24'h000000;
	localparam logic [23:0] CNT_RST = 24'h000000;
	localparam logic [23:0] CNT_SAT = 24'hFFFFFF;

	// ----------------------------------------
	// Interrupt status bits.
	// ----------------------------------------
	localparam int IRQ_RAISE = 0;
	localparam int IRQ_ACK = 1;
	localparam int IRQ_HOUR = 2;
	localparam int IRQ_W = 3;

	// ----------------------------------------
	// Time base.
	// ----------------------------------------
	localparam int unsigned SEC_MS = 1000;
	localparam int unsigned CLK_KHZ = 50000;
	localparam int unsigned CYC_PER_SEC = SEC_MS * CLK_KHZ;
	localparam logic [11:0] SEC_PER_HOUR = 12'hE10;
	localparam logic [4:0] HOUR_PER_DAY = 5'h18;

endpackage

//--- hdl/sic_evt_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries the time tick and the selected binary signals into the core.
interface sic_evt_if;
	logic sec_tick;
	logic mon_on;
	logic mon_rise;
	logic ack_on;

	modport tick_src (output sec_tick);
	modport sel_src (output mon_on, output mon_rise, output ack_on);
	modport core (input sec_tick, input mon_on, input mon_rise, input ack_on);
endinterface

`default_nettype wire

//--- hdl/sic_timebase.sv
`timescale 1ns/10ps
`default_nettype none

module sic_timebase import sic_pkg::*; #(
	parameter int unsigned CYC_SEC = CYC_PER_SEC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Tick output.
	sic_evt_if.tick_src ev
);

	logic [31:0] div;
	logic [31:0] next_div;
	logic next_tick;

	// Divides the clock down to a one-cycle pulse per second.
	always_comb begin
		next_tick = 1'b0;
		next_div = div + 32'h00000001;
		if (div >= CYC_SEC - 1) begin
			next_div = 32'h00000000;
			next_tick = 1'b1;
		end
	end

	// Registers the divider and the tick.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div <= 32'h00000000;
			ev.sec_tick <= 1'b0;
		end else begin
			div <= next_div;
			ev.sec_tick <= next_tick;
		end
	end

endmodule

`default_nettype wire

//--- hdl/sic_select.sv
`timescale 1ns/10ps
`default_nettype none

module sic_select import sic_pkg::*; (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Binary signals and selectors.
	input wire logic [NBIN-1:0] bin_in,
	input wire logic [3:0] mon_sel,
	input wire logic [3:0] ack_sel,
	// Selected signals.
	sic_evt_if.sel_src ev
);

	logic [NBIN-1:0] sync1;
	logic [NBIN-1:0] sync2;
	logic next_mon;
	logic next_ack;

	// Picks one synchronised signal; selector zero means nothing selected.
	function automatic logic pick(input logic [NBIN-1:0] v, input logic [3:0] sel);
		logic r;
		r = 1'b0;
		if (sel != SEL_NONE && sel <= 4'(NBIN))
			r = v[3'(sel - 4'h1)];
		return r;
	endfunction

	always_comb begin
		next_mon = pick(sync2, mon_sel);
		next_ack = pick(sync2, ack_sel);
	end

	// Two-stage synchroniser, then the selected levels and the switch-on edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '0;
			sync2 <= '0;
			ev.mon_on <= 1'b0;
			ev.mon_rise <= 1'b0;
			ev.ack_on <= 1'b0;
		end else begin
			sync1 <= bin_in;
			sync2 <= sync1;
			ev.mon_on <= next_mon;
			ev.mon_rise <= next_mon & ~ev.mon_on;
			ev.ack_on <= next_ack;
		end
	end

endmodule

`default_nettype wire

//--- hdl/sic_top.sv
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module sic_top import sic_pkg::*; #(
	parameter int unsigned CYC_SEC = CYC_PER_SEC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Binary signals.
	input wire logic [NBIN-1:0] bin_in,
	// Status outputs.
	output logic svc_flag,
	output logic nv_save,
	output logic irq
);

	sic_evt_if ev ();
	logic [CTRL_W-1:0] ctrl;
	logic [CNT_W-1:0] limit;
	logic [CNT_W-1:0] svc_cnt;
	logic [CNT_W-1:0] op_cnt;
	logic [11:0] svc_sec;
	logic [4:0] svc_hr;
	logic [11:0] op_sec;
	logic [4:0] op_hr;
	logic [11:0] dev_sec;
	logic [IRQ_W-1:0] irq_st;
	logic [IRQ_W-1:0] irq_en;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [1:0] fn;
	logic [1:0] op_mode;
	logic [3:0] mon_sel;
	logic [3:0] ack_sel;
	assign fn = ctrl[CTRL_FN_LSB +: 2];
	assign op_mode = ctrl[CTRL_OP_LSB +: 2];
	assign mon_sel = ctrl[CTRL_MON_LSB +: 4];
	assign ack_sel = ctrl[CTRL_ACK_LSB +: 4];

	sic_timebase #(.CYC_SEC(CYC_SEC)) u_tb (
		.hclk(hclk),
		.hresetn(hresetn),
		.ev(ev.tick_src)
	);

	sic_select u_sel (
		.hclk(hclk),
		.hresetn(hresetn),
		.bin_in(bin_in),
		.mon_sel(mon_sel),
		.ack_sel(ack_sel),
		.ev(ev.sel_src)
	);

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------

	// Advances seconds and hours; returns {sec, hour, unit done}.
	function automatic logic [17:0] step_time(input logic [11:0] sec, input logic [4:0] hr,
			input logic days, input logic run);
		logic [11:0] s;
		logic [4:0] h;
		logic wrap;
		logic last_hr;
		wrap = run && (sec == SEC_PER_HOUR - 12'h001);
		last_hr = (hr == HOUR_PER_DAY - 5'h01);
		s = wrap ? 12'h000 : sec + 12'(run);
		h = (wrap && days) ? (last_hr ? 5'h00 : hr + 5'h01) : hr;
		return {s, h, wrap && (!days || last_hr)};
	endfunction

	// Saturating increment of a counter.
	function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
		return (v == CNT_SAT) ? v : v + 24'h000001;
	endfunction

	// ----------------------------------------
	// Bus slave.
	// ----------------------------------------
	logic acc;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [31:0] next_rdata;
	logic cfg_wr;
	logic svc_wr;
	logic opt_wr;
	logic clr_wr;
	assign acc = hsel & hready & htrans[1];
	assign cfg_wr = wr_pend && (wr_addr == ADDR_CTRL || wr_addr == ADDR_LIMIT);
	assign svc_wr = wr_pend && wr_addr == ADDR_SVC;
	assign opt_wr = wr_pend && wr_addr == ADDR_OPT;
	assign clr_wr = wr_pend && wr_addr == ADDR_CLR;

	// Decodes the address phase; read data is prepared for the data phase.
	always_comb begin
		next_wr_pend = acc & hwrite;
		next_wr_addr = acc ? haddr : wr_addr;
		next_rdata = 32'h00000000;
		if (acc && !hwrite) begin
			unique case (haddr)
				ADDR_CTRL: next_rdata = 32'(ctrl);
				ADDR_LIMIT: next_rdata = 32'(limit);
				ADDR_SVC: next_rdata = 32'(svc_cnt);
				ADDR_OPT: next_rdata = 32'(op_cnt);
				ADDR_STAT: next_rdata = 32'(irq_st);
				ADDR_EN: next_rdata = 32'(irq_en);
				ADDR_FLAG: next_rdata = 32'(svc_flag);
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	// Registers the bus state; the slave is always ready and always OKAY.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_rdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------
	// Configuration.
	// ----------------------------------------
	logic [CTRL_W-1:0] next_ctrl;
	logic [CNT_W-1:0] next_limit;
	logic [IRQ_W-1:0] next_irq_en;

	// Applies writes; a limit above ten million is clipped to it.
	always_comb begin
		next_ctrl = ctrl;
		next_limit = limit;
		next_irq_en = irq_en;
		if (wr_pend && wr_addr == ADDR_CTRL)
			next_ctrl = hwdata[CTRL_W-1:0];
		if (wr_pend && wr_addr == ADDR_LIMIT)
			next_limit = (hwdata > 32'(LIMIT_MAX)) ? LIMIT_MAX : hwdata[CNT_W-1:0];
		if (wr_pend && wr_addr == ADDR_EN)
			next_irq_en = hwdata[IRQ_W-1:0];
	end

	// Registers the configuration.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RST;
			limit <= LIMIT_RST;
			irq_en <= '0;
		end else begin
			ctrl <= next_ctrl;
			limit <= next_limit;
			irq_en <= next_irq_en;
		end
	end

	// ----------------------------------------
	// Service and operating counters.
	// ----------------------------------------
	logic [CNT_W-1:0] next_svc_cnt;
	logic [CNT_W-1:0] next_op_cnt;
	logic [11:0] next_svc_sec;
	logic [4:0] next_svc_hr;
	logic [11:0] next_op_sec;
	logic [4:0] next_op_hr;
	logic [11:0] next_dev_sec;
	logic next_flag;
	logic next_nv;
	logic ack_act;
	logic dur_run;
	logic [17:0] svc_step;
	logic [17:0] op_step;
	logic [17:0] dev_step;
	assign ack_act = (ack_sel != SEL_NONE) && ev.ack_on;
	assign dur_run = (mon_sel != SEL_NONE) && (fn == FN_HOURS || fn == FN_DAYS) && ev.mon_on && ev.sec_tick;

	// Counts events or on-time, raises the flag at the limit, honours acknowledge.
	always_comb begin
		svc_step = step_time(svc_sec, svc_hr, fn == FN_DAYS, dur_run);
		op_step = step_time(op_sec, op_hr, op_mode == OP_DAYS, ev.sec_tick);
		dev_step = step_time(dev_sec, 5'h00, 1'b0, ev.sec_tick);
		next_svc_sec = svc_step[17:6];
		next_svc_hr = svc_step[5:1];
		next_svc_cnt = svc_cnt;
		if (svc_step[0])
			next_svc_cnt = inc_sat(svc_cnt);
		if (mon_sel != SEL_NONE && fn == FN_SWITCH && ev.mon_rise)
			next_svc_cnt = inc_sat(svc_cnt);
		next_flag = svc_flag;
		if (limit != LIMIT_RST && next_svc_cnt >= limit)
			next_flag = 1'b1;
		if (svc_wr) begin
			next_svc_cnt = hwdata[CNT_W-1:0];
			next_svc_sec = 12'h000;
			next_svc_hr = 5'h00;
		end
		if (ack_act || cfg_wr) begin
			next_svc_cnt = CNT_RST;
			next_svc_sec = 12'h000;
			next_svc_hr = 5'h00;
			next_flag = 1'b0;
		end
		next_op_sec = op_step[17:6];
		next_op_hr = op_step[5:1];
		next_op_cnt = op_step[0] ? inc_sat(op_cnt) : op_cnt;
		if (opt_wr) begin
			next_op_cnt = hwdata[CNT_W-1:0];
			next_op_sec = 12'h000;
			next_op_hr = 5'h00;
		end
		if (op_mode != OP_HOURS && op_mode != OP_DAYS) begin
			next_op_cnt = CNT_RST;
			next_op_sec = 12'h000;
			next_op_hr = 5'h00;
		end
		next_dev_sec = dev_step[17:6];
		next_nv = dev_step[0];
	end

	// Registers the counters and the flag.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			svc_cnt <= CNT_RST;
			op_cnt <= CNT_RST;
			svc_sec <= 12'h000;
			svc_hr <= 5'h00;
			op_sec <= 12'h000;
			op_hr <= 5'h00;
			dev_sec <= 12'h000;
			svc_flag <= 1'b0;
			nv_save <= 1'b0;
		end else begin
			svc_cnt <= next_svc_cnt;
			op_cnt <= next_op_cnt;
			svc_sec <= next_svc_sec;
			svc_hr <= next_svc_hr;
			op_sec <= next_op_sec;
			op_hr <= next_op_hr;
			dev_sec <= next_dev_sec;
			svc_flag <= next_flag;
			nv_save <= next_nv;
		end
	end

	// ----------------------------------------
	// Interrupts.
	// ----------------------------------------
	logic [IRQ_W-1:0] next_irq_st;
	logic [IRQ_W-1:0] irq_set;
	// Sticky status; a new event wins over a clear in the same cycle.
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_RAISE] = next_flag & ~svc_flag;
		irq_set[IRQ_ACK] = ack_act & svc_flag;
		irq_set[IRQ_HOUR] = next_nv;
		next_irq_st = irq_st;
		if (clr_wr)
			next_irq_st = irq_st & ~hwdata[IRQ_W-1:0];
		next_irq_st = next_irq_st | irq_set;
	end

	// Registers status and the level interrupt.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_st <= '0;
			irq <= 1'b0;
		end else begin
			irq_st <= next_irq_st;
			irq <= |(next_irq_st & next_irq_en);
		end
	end

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_flag_sticky: assert property ($fell(svc_flag) |-> $past(ack_act) || $past(cfg_wr))
		else $error("service flag dropped without acknowledge");
	chk_ack_clears: assert property (ack_act |=> !svc_flag && svc_cnt == CNT_RST)
		else $error("acknowledge did not clear flag and count");
	chk_flag_reach: assert property (limit != LIMIT_RST && svc_cnt >= limit && !ack_act && !cfg_wr |=> svc_flag)
		else $error("flag not raised at limit");
	chk_switch_count: assert property (mon_sel != SEL_NONE && fn == FN_SWITCH && ev.mon_rise && !ack_act
		&& !cfg_wr && !svc_wr && svc_cnt != CNT_SAT |=> svc_cnt == $past(svc_cnt) + 24'h000001)
		else $error("switch event not counted");
	chk_no_monitor: assert property (mon_sel == SEL_NONE && !svc_wr |=> svc_cnt == $past(svc_cnt) || svc_cnt == CNT_RST)
		else $error("count advanced with no monitored signal");
	chk_dur_tick: assert property ($past(fn) != FN_SWITCH && !$past(svc_wr)
		&& svc_cnt == $past(svc_cnt) + 24'h000001 |-> $past(ev.sec_tick) && $past(ev.mon_on))
		else $error("duration count moved without on-time");
	chk_op_off: assert property (op_mode == OP_OFF |=> op_cnt == CNT_RST)
		else $error("operating counter not cleared when off");
	chk_op_tick: assert property (!$past(opt_wr) && op_cnt == $past(op_cnt) + 24'h000001 |-> $past(ev.sec_tick))
		else $error("operating counter moved without a tick");
	chk_limit_range: assert property (limit <= LIMIT_MAX)
		else $error("limit above ten million");
	chk_nv_pulse: assert property (nv_save |=> !nv_save)
		else $error("save strobe longer than one cycle");
	cov_flag_raise: cover property ($rose(svc_flag));
	cov_ack: cover property (svc_flag ##1 ack_act ##1 !svc_flag);
	cov_irq: cover property ($rose(irq));

endmodule

`default_nettype wire

//--- dv/sic_bin_src.sv
`timescale 1ns/10ps
`default_nettype none

module sic_bin_src (
	// Clock.
	input wire logic hclk,
	// Binary signals towards the block.
	output logic [7:0] bin_out
);
	// All signals start switched off.
	initial begin
		bin_out = 8'h00;
	end

	// One switch-on event.
	// Both phases last at least two cycles, so the synchroniser sees every edge.
	task automatic pulse(input int ch, input int hi, input int lo);
		@(posedge hclk);
		bin_out[ch] <= 1'b1;
		repeat ((hi < 2) ? 2 : hi) @(posedge hclk);
		bin_out[ch] <= 1'b0;
		repeat ((lo < 2) ? 2 : lo) @(posedge hclk);
	endtask

	// Sets a level, such as a long on-time or a high acknowledgement.
	task automatic set(input int ch, input logic v);
		@(posedge hclk);
		bin_out[ch] <= v;
	endtask
endmodule

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench import sic_pkg::*; ();
	// ----------------------------------------
	// Signals and instances.
	// ----------------------------------------
	localparam int CS = 2;
	localparam int HOUR = 3600 * CS;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [7:0] bin_in;
	logic svc_flag;
	logic nv_save;
	logic irq;
	int error_cnt = 0;
	int checks_done = 0;
	int saves = 0;
	int m_cnt;
	int m_lim;
	logic [31:0] seed = 32'h4CD0AE27;

	// Free-running bus clock.
	always #10 hclk = ~hclk;

	sic_top #(.CYC_SEC(CS)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .bin_in(bin_in), .svc_flag(svc_flag), .nv_save(nv_save), .irq(irq));

	sic_bin_src pm (.hclk(hclk), .bin_out(bin_in));

	// Counts the hourly save strobes.
	always @(posedge hclk) begin
		if (nv_save === 1'b1) begin
			saves <= saves + 1;
		end
	end

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// Waits for the edge at which the slave is ready, with a bound.
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n <= 16) begin
			n++;
			@(posedge hclk);
		end
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t: bus never ready", $time);
			conclude();
		end
	endtask

	// One single word transfer: address phase, then data phase.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		check(q, exp);
	endtask

	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Every register and one unmapped word read zero after reset.
		for (int a = 0; a < 9; a++) begin
			rd_chk(8'(a * 4), 32'h00000000);
		end
		check(32'(svc_flag), 32'h00000000);
		check(32'(irq), 32'h00000000);
		check({30'h00000000, hreadyout, hresp}, 32'h00000002);
		$display("test reset done");

		// Every function and operating mode code is accepted.
		for (int f = 0; f < 3; f++) begin
			wr(ADDR_CTRL, {20'h00000, 4'h2, 4'h1, 2'(f), 2'(f)});
			rd_chk(ADDR_CTRL, {20'h00000, 4'h2, 4'h1, 2'(f), 2'(f)});
		end
		wr(ADDR_LIMIT, 32'h00FFFFFF);
		rd_chk(ADDR_LIMIT, 32'h00989680);
		m_lim = 2 + int'(rnd() % 4);
		wr(ADDR_LIMIT, 32'(m_lim));
		rd_chk(ADDR_LIMIT, 32'(m_lim));
		$display("test config done");

		// Switch counting up to and past the limit; the flag holds.
		wr(ADDR_EN, 32'h00000001);
		wr(ADDR_CTRL, 32'h00000210);
		m_cnt = 0;
		for (int i = 0; i < m_lim + 2; i++) begin
			pm.pulse(0, 2 + int'(rnd() % 3), 2 + int'(rnd() % 3));
			pm.pulse(4, 2, 2);
			cyc(5);
			m_cnt++;
			rd_chk(ADDR_SVC, 32'(m_cnt));
			check(32'(svc_flag), 32'(m_cnt >= m_lim));
			check(32'(irq), 32'(m_cnt >= m_lim));
		end
		wr(ADDR_EN, 32'h00000000);
		cyc(2);
		check(32'(irq), 32'h00000000);
		wr(ADDR_EN, 32'h00000003);
		$display("test switch count done");

		// A high acknowledgement clears the flag and restarts the count.
		pm.set(1, 1'b1);
		cyc(6);
		check(32'(svc_flag), 32'h00000000);
		rd_chk(ADDR_SVC, 32'h00000000);
		pm.set(1, 1'b0);
		rd_chk(ADDR_STAT, 32'h00000003);
		wr(ADDR_CLR, 32'h00000007);
		cyc(2);
		rd_chk(ADDR_STAT, 32'h00000000);
		check(32'(irq), 32'h00000000);
		$display("test acknowledge done");

		// Without a monitored signal nothing is counted.
		wr(ADDR_CTRL, 32'h00000200);
		pm.pulse(0, 3, 3);
		cyc(5);
		rd_chk(ADDR_SVC, 32'h00000000);
		$display("test no monitor done");

		// One hour of on-time and of running time, then the counter off.
		wr(ADDR_LIMIT, 32'h00000001);
		wr(ADDR_EN, 32'h00000004);
		wr(ADDR_CTRL, 32'h00000215);
		pm.set(0, 1'b1);
		cyc(HOUR + 40);
		rd_chk(ADDR_SVC, 32'h00000001);
		check(32'(svc_flag), 32'h00000001);
		rd_chk(ADDR_FLAG, 32'h00000001);
		rd_chk(ADDR_OPT, 32'h00000001);
		check(32'(saves > 0), 32'h00000001);
		check(32'(irq), 32'h00000001);
		wr(ADDR_SVC, 32'h00000007);
		rd_chk(ADDR_SVC, 32'h00000007);
		wr(ADDR_CTRL, 32'h00000211);
		cyc(2);
		rd_chk(ADDR_OPT, 32'h00000000);
		pm.set(0, 1'b0);
		$display("test hours done");
		conclude();
	end

	// Cuts a hung run short.
	initial begin
		repeat (100000) @(posedge hclk);
		error_cnt++;
		$display("ERROR %0t: run too long", $time);
		conclude();
	end
endmodule

`default_nettype wire
